/* include/stack_cpu_consts.svh */
// constants for the stack processor decode block: widths, reset values, code tables
`ifndef STACK_CPU_CONSTS_SVH
`define STACK_CPU_CONSTS_SVH

// ---------------------------------------------
// datapath geometry
// ---------------------------------------------
`define SCD_WORD_W      16
`define SCD_INSTR_W     8
`define SCD_NIB_W       4
`define SCD_BYTES_LOG2  1

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define SCD_WPTR_RESET  16'h0000
`define SCD_IPTR_RESET  16'h0000
`define SCD_OREG_RESET  16'h0000
`define SCD_STACK_RESET 16'h0000

// ---------------------------------------------
// function code table, one place to change it
// ---------------------------------------------
`define FN_LOAD_CONST   4'h0
`define FN_ADD_CONST    4'h1
`define FN_LOAD_LOCAL   4'h2
`define FN_STORE_LOCAL  4'h3
`define FN_LOCAL_PTR    4'h4
`define FN_LOAD_FAR     4'h5
`define FN_STORE_FAR    4'h6
`define FN_JUMP         4'h7
`define FN_COND_JUMP    4'h8
`define FN_CALL         4'h9
`define FN_PREFIX       4'ha
`define FN_NEG_PREFIX   4'hb
`define FN_OPERATE      4'hc

// ---------------------------------------------
// operate codes carried in the operand
// ---------------------------------------------
`define OPR_ADD         16'h0000
`define OPR_SUB         16'h0001
`define OPR_XOR         16'h0002
`define OPR_GT          16'h0003
`define OPR_REV         16'h0004

`endif

/* include/stack_cpu_pkg.sv */
// types shared by the stack processor decode block
package stack_cpu_pkg;

	typedef enum logic [2:0] {
		STK_HOLD    = 3'b000,
		STK_PUSH    = 3'b001,
		STK_POP     = 3'b010,
		STK_SETA    = 3'b011,
		STK_SETAPOP = 3'b100,
		STK_POP2    = 3'b101,
		STK_SWAP    = 3'b110
	} stackOp_t;

	typedef enum logic [0:0] {
		S_EXEC = 1'b0,
		S_MEM  = 1'b1
	} state_t;

endpackage : stack_cpu_pkg

/* rtl/eval_stack.sv */
// three-entry evaluation stack with push, pop and top replacement
`timescale 1ns/1ps
`include "stack_cpu_consts.svh"

module eval_stack #(
	parameter int WORD_W = `SCD_WORD_W
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire stack_cpu_pkg::stackOp_t op,
	input  wire logic [WORD_W-1:0]     din,
	output logic      [WORD_W-1:0]     topA,
	output logic      [WORD_W-1:0]     midB,
	output logic      [WORD_W-1:0]     botC
);
	import stack_cpu_pkg::*;

	// ---------------------------------------------
	// stack registers
	// ---------------------------------------------
	logic [WORD_W-1:0] topA_r;
	logic [WORD_W-1:0] midB_r;
	logic [WORD_W-1:0] botC_r;

	// no depth counter on purpose: overflow is the program's problem
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			topA_r <= WORD_W'(`SCD_STACK_RESET);
			midB_r <= WORD_W'(`SCD_STACK_RESET);
			botC_r <= WORD_W'(`SCD_STACK_RESET);
		end else begin
			unique case (op)
				STK_HOLD: begin
				end
				STK_PUSH: begin
					botC_r <= midB_r;
					midB_r <= topA_r;
					topA_r <= din;
				end
				STK_POP: begin
					topA_r <= midB_r;
					midB_r <= botC_r;
				end
				STK_SETA: begin
					topA_r <= din;
				end
				STK_SETAPOP: begin
					topA_r <= din;
					midB_r <= botC_r;
				end
				STK_POP2: begin
					topA_r <= botC_r;
					midB_r <= botC_r;
				end
				STK_SWAP: begin
					topA_r <= midB_r;
					midB_r <= topA_r;
				end
				default: begin
				end
			endcase
		end
	end

	assign topA = topA_r;
	assign midB = midB_r;
	assign botC = botC_r;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_pushShift;
		op == STK_PUSH |=> topA == $past(din) && midB == $past(topA) && botC == $past(midB);
	endproperty
	a_pushShift: assert property (p_pushShift) else $error("push did not shift the stack");

	property p_popShift;
		op == STK_POP |=> topA == $past(midB) && midB == $past(botC);
	endproperty
	a_popShift: assert property (p_popShift) else $error("pop did not shift the stack");

endmodule : eval_stack

/* rtl/stack_cpu_decode.sv */
// instruction decode and register datapath of the 16-bit stack processor
// Operation
// - byte splits into function and data nibble
// - sixteen codes, thirteen decoded: ten direct functions plus prefix, negative prefix and operate
// - load local pushes B to C, A to B; load far only replaces A
// - store local pops B to A, C to B; store far moves C to both A and B
// - add sums top two, pops stack
// - no stack overflow detection logic
// - load constant pushes 0..15 in one byte
// - local access at workspace plus operand
// - non-local access at A plus operand
// - exactly six execution registers
// - iptr holds next instruction address
// - 16-bit words, 64 Kbyte address space
// - nibble into operand low bits, then clear
// - prefix shifts left four, negative complements
// - operate decodes operand as stack operation
`timescale 1ns/1ps
`include "stack_cpu_consts.svh"

module stack_cpu_decode #(
	parameter int WORD_W = `SCD_WORD_W
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                instrValid,
	input  wire logic [7:0]          instrByte,
	output logic                     instrReady,
	output logic      [WORD_W-1:0]   fetchAddr,
	output logic                     jumpTaken,
	output logic                     memReq,
	output logic                     memWe,
	output logic      [WORD_W-1:0]   memAddr,
	output logic      [WORD_W-1:0]   memWdata,
	input  wire logic [WORD_W-1:0]   memRdata,
	input  wire logic                memAck,
	output logic      [WORD_W-1:0]   wptrOut,
	output logic      [WORD_W-1:0]   oregOut,
	output logic      [WORD_W-1:0]   stackA,
	output logic      [WORD_W-1:0]   stackB,
	output logic      [WORD_W-1:0]   stackC
);
	import stack_cpu_pkg::*;

	// ---------------------------------------------
	// elaboration check
	// ---------------------------------------------
	// byte addresses over 64 Kbytes need exactly a 16-bit word
	if (WORD_W != 16) begin : g_badWidth
		$error("stack_cpu_decode: WORD_W must be 16");
	end

	// ---------------------------------------------
	// registers: wptr, iptr, oreg here, A/B/C in the stack
	// ---------------------------------------------
	state_t            state_r;
	state_t            state_nxt;
	logic [WORD_W-1:0] wptr_r;
	logic [WORD_W-1:0] iptr_r;
	logic [WORD_W-1:0] iptr_nxt;
	logic [WORD_W-1:0] oreg_r;
	logic [WORD_W-1:0] oreg_nxt;
	stackOp_t          pendOp_r;
	logic              jumpTaken_r;
	logic              memWe_r;
	logic [WORD_W-1:0] memAddr_r;
	logic [WORD_W-1:0] memWdata_r;

	// ---------------------------------------------
	// field split and function decode
	// ---------------------------------------------
	wire [3:0] fnCode = instrByte[7:4];
	wire [3:0] nibble = instrByte[3:0];
	wire       take   = (state_r == S_EXEC) && instrValid;

	// all code compares go through the one table
	wire isLdConst  = fnCode == `FN_LOAD_CONST;
	wire isAddConst = fnCode == `FN_ADD_CONST;
	wire isLdLocal  = fnCode == `FN_LOAD_LOCAL;
	wire isStLocal  = fnCode == `FN_STORE_LOCAL;
	wire isLocalPtr = fnCode == `FN_LOCAL_PTR;
	wire isLdFar    = fnCode == `FN_LOAD_FAR;
	wire isStFar    = fnCode == `FN_STORE_FAR;
	wire isJump     = fnCode == `FN_JUMP;
	wire isCondJump = fnCode == `FN_COND_JUMP;
	wire isCall     = fnCode == `FN_CALL;
	wire isPrefix   = fnCode == `FN_PREFIX;
	wire isNegPfx   = fnCode == `FN_NEG_PREFIX;
	wire isOperate  = fnCode == `FN_OPERATE;
	wire isMemOp    = isLdLocal | isStLocal | isLdFar | isStFar;

	// ---------------------------------------------
	// operand formation
	// ---------------------------------------------
	wire [WORD_W-1:0] operand   = oreg_r | {{(WORD_W-4){1'b0}}, nibble};
	wire [WORD_W-1:0] pfxNext   = {operand[WORD_W-5:0], 4'h0};
	wire [WORD_W-1:0] operandN  = ~operand;
	wire [WORD_W-1:0] nfxNext   = {operandN[WORD_W-5:0], 4'h0};
	wire [WORD_W-1:0] wordOffs  = {operand[WORD_W-2:0], 1'b0};

	// ---------------------------------------------
	// addresses
	// ---------------------------------------------
	wire [WORD_W-1:0] localAddr = wptr_r + wordOffs;
	wire [WORD_W-1:0] farAddr   = stackA + wordOffs;
	wire [WORD_W-1:0] seqIptr   = iptr_r + 16'h0001;
	wire [WORD_W-1:0] jmpTarget = seqIptr + operand;
	wire              aIsZero   = stackA == '0;
	wire              flowJump  = isJump | isCall | (isCondJump & aIsZero);

	// ---------------------------------------------
	// operate unit
	// ---------------------------------------------
	wire [WORD_W-1:0] aluAdd = stackB + stackA;
	wire [WORD_W-1:0] aluSub = stackB - stackA;
	wire [WORD_W-1:0] aluXor = stackB ^ stackA;
	wire [WORD_W-1:0] aluGt  = {{(WORD_W-1){1'b0}}, $signed(stackB) > $signed(stackA)};
	wire [WORD_W-1:0] adcSum = stackA + operand;

	// operand selects what happens to the stack
	wire oprAdd = isOperate && operand == `OPR_ADD;
	wire oprSub = isOperate && operand == `OPR_SUB;
	wire oprXor = isOperate && operand == `OPR_XOR;
	wire oprGt  = isOperate && operand == `OPR_GT;
	wire oprRev = isOperate && operand == `OPR_REV;

	// ---------------------------------------------
	// stack control for the instruction in hand
	// ---------------------------------------------
	stackOp_t          execOp;
	logic [WORD_W-1:0] execVal;
	stackOp_t          memOp;

	always_comb begin
		execOp  = STK_HOLD;
		execVal = '0;
		if (isLdConst) begin
			execOp  = STK_PUSH;
			execVal = operand;
		end else if (isAddConst) begin
			execOp  = STK_SETA;
			execVal = adcSum;
		end else if (isLocalPtr) begin
			execOp  = STK_PUSH;
			execVal = localAddr;
		end else if (isCall) begin
			execOp  = STK_PUSH;
			execVal = seqIptr;
		end else if (isCondJump && !aIsZero) begin
			execOp  = STK_POP;
		end else if (oprAdd) begin
			execOp  = STK_SETAPOP;
			execVal = aluAdd;
		end else if (oprSub) begin
			execOp  = STK_SETAPOP;
			execVal = aluSub;
		end else if (oprXor) begin
			execOp  = STK_SETAPOP;
			execVal = aluXor;
		end else if (oprGt) begin
			execOp  = STK_SETAPOP;
			execVal = aluGt;
		end else if (oprRev) begin
			execOp  = STK_SWAP;
		end
	end

	// stack moves for memory ops wait for the answer, so A stays the address source
	always_comb begin
		memOp = STK_HOLD;
		if (isLdLocal) begin
			memOp = STK_PUSH;
		end else if (isStLocal) begin
			memOp = STK_POP;
		end else if (isLdFar) begin
			memOp = STK_SETA;
		end else if (isStFar) begin
			memOp = STK_POP2;
		end
	end

	wire      memDone = (state_r == S_MEM) && memAck;
	stackOp_t stkOp;
	assign stkOp = memDone ? pendOp_r : (take && !isMemOp) ? execOp : STK_HOLD;
	wire [WORD_W-1:0] stkVal = memDone ? memRdata : execVal;

	eval_stack #(
		.WORD_W (WORD_W)
	) u_stack (
		.clk   (clk),
		.rst_n (rst_n),
		.op    (stkOp),
		.din   (stkVal),
		.topA  (stackA),
		.midB  (stackB),
		.botC  (stackC)
	);

	// ---------------------------------------------
	// next-state decode
	// ---------------------------------------------
	// prefixes keep building, everything else leaves a clean operand
	assign oreg_nxt  = !take ? oreg_r : isPrefix ? pfxNext : isNegPfx ? nfxNext : '0;
	assign iptr_nxt  = !take ? iptr_r : flowJump ? jmpTarget : seqIptr;
	assign state_nxt = (take && isMemOp) ? S_MEM : memDone ? S_EXEC : state_r;

	// ---------------------------------------------
	// state registers
	// ---------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r     <= S_EXEC;
			wptr_r      <= WORD_W'(`SCD_WPTR_RESET);
			iptr_r      <= WORD_W'(`SCD_IPTR_RESET);
			oreg_r      <= WORD_W'(`SCD_OREG_RESET);
			jumpTaken_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			iptr_r      <= iptr_nxt;
			oreg_r      <= oreg_nxt;
			jumpTaken_r <= take && flowJump;
		end
	end

	// memory request is captured once; the address cannot drift while A moves
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pendOp_r   <= STK_HOLD;
			memWe_r    <= 1'b0;
			memAddr_r  <= '0;
			memWdata_r <= '0;
		end else if (take && isMemOp) begin
			pendOp_r   <= memOp;
			memWe_r    <= isStLocal | isStFar;
			memAddr_r  <= (isLdFar | isStFar) ? farAddr : localAddr;
			memWdata_r <= isStFar ? stackB : stackA;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign instrReady = state_r == S_EXEC;
	assign memReq     = state_r == S_MEM;
	assign memWe      = memWe_r;
	assign memAddr    = memAddr_r;
	assign memWdata   = memWdata_r;
	assign fetchAddr  = iptr_r;
	assign jumpTaken  = jumpTaken_r;
	assign wptrOut    = wptr_r;
	assign oregOut    = oreg_r;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire [WORD_W-1:0] nibWide = {{(WORD_W-4){1'b0}}, nibble};
	wire              plainLc = take && isLdConst && oreg_r == '0;
	// low nibble of oreg is always clear, so a sum rebuilds the operand independently
	wire [WORD_W-1:0] chkOp   = oreg_r + nibWide;

	property p_ldConst;
		plainLc |=> stackA == $past(nibWide) && stackB == $past(stackA);
	endproperty
	a_ldConst: assert property (p_ldConst) else $error("load constant value wrong");

	property p_oregClear;
		take && !isPrefix && !isNegPfx |=> oreg_r == '0;
	endproperty
	a_oregClear: assert property (p_oregClear) else $error("operand not cleared");

	property p_prefix;
		take && isPrefix |=> oreg_r == ($past(chkOp) << 4);
	endproperty
	a_prefix: assert property (p_prefix) else $error("prefix shift wrong");

	property p_negPrefix;
		take && isNegPfx |=> oreg_r == (~$past(chkOp) << 4);
	endproperty
	a_negPrefix: assert property (p_negPrefix) else $error("negative prefix wrong");

	property p_iptrStep;
		take && !flowJump |=> iptr_r == $past(iptr_r) + 16'h0001 && !jumpTaken;
	endproperty
	a_iptrStep: assert property (p_iptrStep) else $error("iptr did not step one");

	property p_jumpTarget;
		take && flowJump |=> iptr_r == $past(iptr_r) + 16'h0001 + $past(chkOp) && jumpTaken;
	endproperty
	a_jumpTarget: assert property (p_jumpTarget) else $error("jump target wrong");

	property p_localAddr;
		take && (isLdLocal || isStLocal) |=> memReq && memAddr == $past(wptr_r) + ($past(chkOp) << 1);
	endproperty
	a_localAddr: assert property (p_localAddr) else $error("local address wrong");

	property p_farAddr;
		take && (isLdFar || isStFar) |=> memReq && memAddr == $past(stackA) + ($past(chkOp) << 1);
	endproperty
	a_farAddr: assert property (p_farAddr) else $error("non-local address wrong");

	property p_oprAdd;
		take && oprAdd |=> stackA == $past(stackA) + $past(stackB) && stackB == $past(stackC);
	endproperty
	a_oprAdd: assert property (p_oprAdd) else $error("add result wrong");

	property p_memHold;
		memReq && !memAck |=> memReq && !instrReady && $stable(memAddr);
	endproperty
	a_memHold: assert property (p_memHold) else $error("memory request dropped");

	c_prefixThenLoad: cover property (take && isPrefix ##1 take && isLdConst);
	c_localRoundTrip: cover property (take && isLdLocal ##[1:8] memDone);
	c_condTaken:      cover property (take && isCondJump && aIsZero);
	c_operateAdd:     cover property (take && oprAdd);

endmodule : stack_cpu_decode

/* testbench/stack_cpu_decode_test.sv */
// self-checking bench for the stack processor decode block against a behavioural model
`timescale 1ns/1ps
`include "stack_cpu_consts.svh"

module stack_cpu_decode_test;
	import stack_cpu_pkg::*;

	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic        clk;
	logic        rst_n;
	logic        instrValid;
	logic [7:0]  instrByte;
	logic        instrReady;
	logic [15:0] fetchAddr;
	logic        jumpTaken;
	logic        memReq;
	logic        memWe;
	logic [15:0] memAddr;
	logic [15:0] memWdata;
	logic [15:0] memRdata;
	logic        memAck;
	logic [15:0] wptrOut;
	logic [15:0] oregOut;
	logic [15:0] stackA;
	logic [15:0] stackB;
	logic [15:0] stackC;
	int          failures;
	int          testsRun;
	int          iptr;
	int          oreg;
	int          wptr;
	int          sa;
	int          sb;
	int          sc;
	int          expJump;
	int          mem [int];
	logic [7:0]  prog [$];

	stack_cpu_decode #(.WORD_W(16)) dut (
		.clk(clk), .rst_n(rst_n), .instrValid(instrValid), .instrByte(instrByte),
		.instrReady(instrReady), .fetchAddr(fetchAddr), .jumpTaken(jumpTaken),
		.memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata), .memAck(memAck), .wptrOut(wptrOut), .oregOut(oregOut),
		.stackA(stackA), .stackB(stackB), .stackC(stackC)
	);

	always #25 clk = ~clk;

	// ---------------------------------------------
	// model
	// ---------------------------------------------
	function automatic int m16(input int v);
		return v & 32'h0000ffff;
	endfunction : m16

	// unwritten words read back as a pattern of their address, so a wrong address shows up
	function automatic int rd(input int a);
		return mem.exists(a) ? mem[a] : m16(a * 37 + 5);
	endfunction : rd

	task automatic push(input int v);
		sc = sb;
		sb = sa;
		sa = v;
	endtask : push

	task automatic chk(input logic [15:0] got, input int exp, input string what);
		testsRun++;
		if (got !== 16'(exp)) begin
			failures++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, 16'(exp));
		end
	endtask : chk

	task automatic compareAll();
		chk(fetchAddr, iptr, "iptr");
		chk(oregOut, oreg, "oreg");
		chk(stackA, sa, "A");
		chk(stackB, sb, "B");
		chk(stackC, sc, "C");
		chk(wptrOut, wptr, "wptr");
		chk({15'h0000, jumpTaken}, expJump, "jump");
	endtask : compareAll

	task automatic model(input logic [7:0] b, output bit isMem, output bit we, output int addr, output int wd);
		logic [3:0] fn;
		int         op;
		int         nx;
		fn = b[7:4];
		op = m16(oreg | b[3:0]);
		nx = m16(iptr + 1);
		isMem = 1'b0;
		we = 1'b0;
		addr = m16(wptr + 2 * op);
		wd = sa;
		expJump = 0;
		oreg = 0;
		iptr = nx;
		case (fn)
		`FN_LOAD_CONST:  push(op);
		`FN_ADD_CONST:   sa = m16(sa + op);
		`FN_LOAD_LOCAL:  push(rd(addr));
		`FN_STORE_LOCAL: mem[addr] = sa;
		`FN_LOCAL_PTR:   push(addr);
		`FN_LOAD_FAR:    addr = m16(sa + 2 * op);
		`FN_STORE_FAR:   addr = m16(sa + 2 * op);
		`FN_PREFIX:      oreg = m16(op << 4);
		`FN_NEG_PREFIX:  oreg = m16((~op) << 4);
		`FN_CALL:        push(nx);
		default: ;
		endcase
		isMem = fn inside {`FN_LOAD_LOCAL, `FN_STORE_LOCAL, `FN_LOAD_FAR, `FN_STORE_FAR};
		we = fn inside {`FN_STORE_LOCAL, `FN_STORE_FAR};
		if (fn == `FN_STORE_LOCAL) begin
			sa = sb;
			sb = sc;
		end
		if (fn == `FN_LOAD_FAR)
			sa = rd(addr);
		if (fn == `FN_STORE_FAR) begin
			wd = sb;
			mem[addr] = sb;
			sa = sc;
			sb = sc;
		end
		if (fn == `FN_JUMP || fn == `FN_CALL || (fn == `FN_COND_JUMP && sa == 0)) begin
			iptr = m16(nx + op);
			expJump = 1;
		end else if (fn == `FN_COND_JUMP) begin
			sa = sb;
			sb = sc;
		end
		if (fn == `FN_OPERATE && op < 4) begin
			case (op)
			0: sa = m16(sb + sa);
			1: sa = m16(sb - sa);
			2: sa = sb ^ sa;
			default: sa = (shortint'(sb) > shortint'(sa)) ? 1 : 0;
			endcase
			sb = sc;
		end else if (fn == `FN_OPERATE && op == 4) begin
			op = sa;
			sa = sb;
			sb = op;
		end
	endtask : model

	// ---------------------------------------------
	// driver
	// ---------------------------------------------
	// valid stays up after a take, so non-memory bytes go back to back and a pending
	// memory op sees its own byte still offered, which must not be taken twice
	task automatic issue(input logic [7:0] b);
		bit isMem;
		bit we;
		int addr;
		int wd;
		int d;
		instrByte <= b;
		instrValid <= 1'b1;
		@(posedge clk);
		model(b, isMem, we, addr, wd);
		if (isMem) begin
			d = $urandom_range(0, 3);
			memRdata <= 16'(rd(addr));
			memAck <= (d == 0);
			#1;
			chk({15'h0000, memReq}, 1, "req");
			chk({15'h0000, instrReady}, 0, "ready");
			chk({15'h0000, memWe}, we, "we");
			chk(memAddr, addr, "addr");
			if (we)
				chk(memWdata, wd, "wdata");
			repeat (d) @(posedge clk);
			if (d > 0)
				memAck <= 1'b1;
			@(posedge clk);
			memAck <= 1'b0;
			memRdata <= 16'($urandom());
		end
		fork
			begin
				#1;
				compareAll();
			end
		join_none
	endtask : issue

	task automatic doReset(input int n);
		rst_n <= 1'b0;
		instrValid <= 1'b0;
		repeat (n) @(posedge clk);
		rst_n <= 1'b1;
		iptr = 0;
		oreg = 0;
		wptr = 0;
		sa = 0;
		sb = 0;
		sc = 0;
		expJump = 0;
		fork
			begin
				#1;
				compareAll();
				chk({15'h0000, memReq}, 0, "reset req");
				chk({15'h0000, instrReady}, 1, "reset ready");
			end
		join_none
		@(posedge clk);
	endtask : doReset

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", testsRun, failures);
		if (failures == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// ---------------------------------------------
	// sequence
	// ---------------------------------------------
	initial begin
		#1500000;
		failures++;
		finish_test();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		instrValid = 1'b0;
		instrByte = 8'h00;
		memRdata = 16'h0000;
		memAck = 1'b0;
		failures = 0;
		testsRun = 0;
		void'($urandom(32'hcfa463b4));
		doReset(12);
		// five pushes overflow the stack silently, then the small expression programs
		prog = '{{`FN_LOAD_CONST, 4'h1}, {`FN_LOAD_CONST, 4'h2}, {`FN_LOAD_CONST, 4'h3},
			{`FN_LOAD_CONST, 4'hf}, {`FN_LOAD_CONST, 4'h0}, {`FN_STORE_LOCAL, 4'h1},
			{`FN_PREFIX, 4'h2}, {`FN_LOAD_CONST, 4'h4}, {`FN_STORE_LOCAL, 4'h2},
			{`FN_LOAD_LOCAL, 4'h1}, {`FN_LOAD_LOCAL, 4'hf}, {`FN_OPERATE, 4'h0},
			{`FN_STORE_LOCAL, 4'h3}, {`FN_NEG_PREFIX, 4'h0}, {`FN_LOAD_CONST, 4'h5},
			{`FN_COND_JUMP, 4'h0}, {`FN_LOAD_CONST, 4'h0}, {`FN_COND_JUMP, 4'h3},
			{`FN_CALL, 4'hf}, {`FN_JUMP, 4'h4}, {`FN_LOCAL_PTR, 4'h1}, {`FN_LOAD_FAR, 4'h0},
			{`FN_ADD_CONST, 4'h7}, {`FN_LOAD_CONST, 4'h1}, {`FN_STORE_FAR, 4'h2},
			{`FN_OPERATE, 4'h1}, {`FN_OPERATE, 4'h2}, {`FN_OPERATE, 4'h3},
			{`FN_OPERATE, 4'h4}, {`FN_OPERATE, 4'h9}, 8'hd7, 8'he0, 8'hff};
		foreach (prog[i])
			issue(prog[i]);
		for (int i = 0; i < 800; i++)
			issue(8'($urandom_range(0, 255)));
		doReset(3);
		for (int i = 0; i < 400; i++)
			issue(8'($urandom_range(0, 255)));
		instrValid <= 1'b0;
		repeat (2) @(posedge clk);
		finish_test();
	end

endmodule : stack_cpu_decode_test
